/* logic/mode_config_params.svh */
// constants for the converter mode configuration register block
// assumes a 32-bit APB slave, one register per aligned word
// Functional notes
// RULE1: bit 3 of the serial link configuration enables the interface time-out, reset 0.
// RULE2: bit 2 of the serial link configuration includes the status byte in read-back, reset 1.
// RULE3: bits 1:0 pick the read-back trailer: none, checksum (reset), CRC, 11 reserved.
// RULE4: bit 7 of conversion setup reverses the primary converter reference polarity.
// RULE5: bit 6 of conversion setup picks continuous (0) or one-shot (1) conversion.
// RULE6: bits 5:4 of conversion setup pick input chop and current rotation options.
// RULE7: bits 3:0 of conversion setup give a start delay of 8.7 us to 8.8 ms, 1100-1111 reserved.
// RULE8: bits 7:5 of filter and bias pick sinc1..sinc4 or FIR (reset), 101-111 reserved.
// RULE9: bit 4 of filter and bias routes sensor bias to the primary or auxiliary converter.
// RULE10: bit 3 of filter and bias sets the sensor bias polarity.
// RULE11: bits 2:0 of filter and bias set bias magnitude: none, 0.5..200 uA, 10 Mohm, 111 reserved.
// RULE12: serial link configuration sits at 02h, resets to 05h, bits 7:4 read zero.
// RULE13: conversion setup sits at 03h, resets to 00h, all bits read/write.
// RULE14: filter and bias setup sits at 04h, resets to 80h, all bits read/write.
// RULE15: with FIR selected only the 2.5, 5, 10 and 20 SPS rates are offered.
// RULE16: the host writes zero to reserved bits and never uses reserved codes.
`ifndef MODE_CONFIG_PARAMS_SVH
`define MODE_CONFIG_PARAMS_SVH

// ----------------------------------------
// register indices, byte address is index * 4
// ----------------------------------------
`define IDX_SERIAL_LINK   8'h02
`define IDX_CONV_SETUP    8'h03
`define IDX_FILTER_BIAS   8'h04
`define IDX_RATE_REQ      8'h05
`define IDX_NONE          8'hFF
// eight index bits above the two byte bits
`define PAGE_SHIFT        10

`define RST_SERIAL_LINK   8'h05
`define RST_CONV_SETUP    8'h00
`define RST_FILTER_BIAS   8'h80
`define RST_RATE_REQ      4'h4
`define SERIAL_LINK_MASK  8'h0F

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_TIMEOUT       3
`define BIT_STATUS        2
`define CRC_HI            1
`define CRC_LO            0
`define BIT_REFERENCE_POLARITY_INVERT        7
`define BIT_RUNSEL        6
`define CHOP_HI           5
`define CHOP_LO           4
`define DELAY_HI          3
`define DELAY_LO          0
`define FILT_HI           7
`define FILT_LO           5
`define BIT_BROUTE        4
`define BIT_BPOL          3
`define BMAG_HI           2
`define BMAG_LO           0

// ----------------------------------------
// codes and limits
// ----------------------------------------
`define CODE_FIR          3'h4
`define DELAY_MAX_CODE    4'hB
`define BMAG_MAX_CODE     3'h6
`define CRC_MAX_CODE      2'h2
`define FIR_MAX_RATE      4'h4
`define FIR_RATE_10       4'h2
`define FIR_RATE_20       4'h4
`define FIR_GAP_RATE      4'h3

// start delay figures in ns, as printed
`define DELAY_NS_TABLE    '{0, 8700, 17000, 35000, 69000, 139000, 278000, 555000, \
	1100000, 2200000, 4400000, 8800000}
`define CLK_NS            20

`endif

/* logic/mode_config_pkg.sv */
// types shared by the mode configuration register block
// assumes the params header is included by the design file
package mode_config_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_CONV  = 3'b100
	} start_state_e;

	typedef struct packed {
		logic [7:0]   serial_link_q;
		logic [7:0]   conv_setup_q;
		logic [7:0]   filter_bias_q;
		logic [3:0]   rate_req_q;
		logic [3:0]   data_rate_q;
		logic [31:0]  prdata_q;
		start_state_e st_q;
		logic [18:0]  delay_cnt_q;
	} regs_s;
endpackage

/* logic/mode_config_regs.sv */
// mode configuration register block with APB access and start-delay sequencer
// assumes pclk at 50 MHz and a host that keeps reserved codes out
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "mode_config_params.svh"

module mode_config_regs #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              conv_start,
	output logic                   conv_begin,
	output logic                   conv_busy,
	input  wire logic              conv_done,
	output logic                   timeout_enable,
	output logic                   status_byte_enable,
	output logic      [1:0]        integrity_select,
	output logic                   reference_polarity_invert,
	output logic                   conversion_run_select,
	output logic      [1:0]        chop_select,
	output logic      [2:0]        filter_select,
	output logic                   bias_converter_route,
	output logic                   bias_polarity,
	output logic      [2:0]        bias_magnitude,
	output logic      [3:0]        data_rate
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	// the index needs three bits; the page check widens paddr to 32
	if (ADDR_W < 5) begin : g_addr_narrow
		$error("ADDR_W too small for the register map");
	end
	if (ADDR_W > 32) begin : g_addr_wide
		$error("ADDR_W wider than the page check can take");
	end

	// ----------------------------------------
	// start delay table in ns, turned into clock cycles
	// ----------------------------------------
	localparam int DLY_NS [12] = `DELAY_NS_TABLE;

	function automatic logic [18:0] delay_cycles(input logic [3:0] code);
		int ns;
		ns = 0;
		if (code <= `DELAY_MAX_CODE)
			ns = DLY_NS[code];
		// least time rounds up
		delay_cycles = 19'((ns + `CLK_NS - 1) / `CLK_NS);
	endfunction

	// conversion start inputs are pins: two flops before use
	logic start_s1_q;
	logic start_s2_q;
	logic start_s3_q;
	logic done_s1_q;
	logic done_s2_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_s1_q <= 1'b0;
			start_s2_q <= 1'b0;
			start_s3_q <= 1'b0;
			done_s1_q  <= 1'b0;
			done_s2_q  <= 1'b0;
		end else begin
			start_s1_q <= conv_start;
			start_s2_q <= start_s1_q;
			start_s3_q <= start_s2_q;
			done_s1_q  <= conv_done;
			done_s2_q  <= done_s1_q;
		end
	end

	logic start_rise;
	assign start_rise = start_s2_q & ~start_s3_q;

	// ----------------------------------------
	// state
	// ----------------------------------------
	mode_config_pkg::regs_s r_q;
	mode_config_pkg::regs_s r_d;

	logic        acc;
	logic        wr;
	logic [7:0]  idx;
	logic        mapped;
	logic        in_page;
	logic        rd_setup;
	logic [7:0]  wbyte;
	logic [2:0]  filt_w;

	assign acc      = psel & penable;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wr       = acc & pwrite & pstrb[0];
	// upper address bits must be zero, or a cut index would alias a register
	assign in_page  = (32'(paddr) >> `PAGE_SHIFT) == 32'h00000000;
	assign idx      = in_page ? 8'(paddr[ADDR_W-1:2]) : `IDX_NONE;
	assign wbyte  = pwdata[7:0];
	assign filt_w = wbyte[`FILT_HI:`FILT_LO];
	assign mapped = (idx == `IDX_SERIAL_LINK) || (idx == `IDX_CONV_SETUP) ||
		(idx == `IDX_FILTER_BIAS) || (idx == `IDX_RATE_REQ);

	always_comb begin
		r_d = r_q;
		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (wr && idx == `IDX_SERIAL_LINK)
			r_d.serial_link_q = wbyte & `SERIAL_LINK_MASK; // RULE12 RULE1 RULE2 RULE3
		if (wr && idx == `IDX_CONV_SETUP)
			r_d.conv_setup_q = wbyte; // RULE13 RULE4 RULE5 RULE6 RULE7
		if (wr && idx == `IDX_FILTER_BIAS)
			r_d.filter_bias_q = wbyte; // RULE14 RULE8 RULE9 RULE10 RULE11
		if (wr && idx == `IDX_RATE_REQ)
			r_d.rate_req_q = pwdata[3:0];

		// ----------------------------------------
		// fir rate clamp: 16.6 SPS and anything above 20 SPS fall back to 20
		// ----------------------------------------
		r_d.data_rate_q = r_d.rate_req_q;
		if (r_d.filter_bias_q[`FILT_HI:`FILT_LO] == `CODE_FIR) begin // RULE15
			if (r_d.rate_req_q > `FIR_MAX_RATE || r_d.rate_req_q == `FIR_GAP_RATE)
				r_d.data_rate_q = `FIR_RATE_20;
		end

		// ----------------------------------------
		// read mux, loaded in the setup cycle so the word stands through access
		// unmapped and out-of-page reads return zero
		// ----------------------------------------
		if (rd_setup) begin
			case (idx)
				`IDX_SERIAL_LINK: r_d.prdata_q = {24'h000000, r_q.serial_link_q}; // RULE12
				`IDX_CONV_SETUP:  r_d.prdata_q = {24'h000000, r_q.conv_setup_q};
				`IDX_FILTER_BIAS: r_d.prdata_q = {24'h000000, r_q.filter_bias_q};
				`IDX_RATE_REQ:    r_d.prdata_q = {28'h0000000, r_q.rate_req_q};
				default:          r_d.prdata_q = 32'h00000000;
			endcase
		end

		// ----------------------------------------
		// start sequencer: delay then conversion
		// ----------------------------------------
		case (r_q.st_q)
			mode_config_pkg::ST_IDLE: begin
				if (start_rise) begin
					r_d.delay_cnt_q = delay_cycles(r_q.conv_setup_q[`DELAY_HI:`DELAY_LO]); // RULE7
					r_d.st_q        = mode_config_pkg::ST_WAIT;
				end
			end
			mode_config_pkg::ST_WAIT: begin
				if (r_q.delay_cnt_q == 19'h00000)
					r_d.st_q = mode_config_pkg::ST_CONV;
				else
					r_d.delay_cnt_q = r_q.delay_cnt_q - 19'h00001;
			end
			mode_config_pkg::ST_CONV: begin
				// one-shot stops after a conversion, continuous keeps going
				if (done_s2_q && r_q.conv_setup_q[`BIT_RUNSEL]) // RULE5
					r_d.st_q = mode_config_pkg::ST_IDLE;
			end
			default: r_d.st_q = mode_config_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q.serial_link_q <= `RST_SERIAL_LINK; // RULE12
			r_q.conv_setup_q  <= `RST_CONV_SETUP; // RULE13
			r_q.filter_bias_q <= `RST_FILTER_BIAS; // RULE14
			r_q.rate_req_q    <= `RST_RATE_REQ;
			r_q.data_rate_q   <= `RST_RATE_REQ;
			r_q.prdata_q      <= 32'h00000000;
			r_q.st_q          <= mode_config_pkg::ST_IDLE;
			r_q.delay_cnt_q   <= 19'h00000;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata  = r_q.prdata_q;
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	assign timeout_enable            = r_q.serial_link_q[`BIT_TIMEOUT]; // RULE1
	assign status_byte_enable        = r_q.serial_link_q[`BIT_STATUS]; // RULE2
	assign integrity_select          = r_q.serial_link_q[`CRC_HI:`CRC_LO]; // RULE3
	assign reference_polarity_invert = r_q.conv_setup_q[`BIT_REFERENCE_POLARITY_INVERT]; // RULE4
	assign conversion_run_select     = r_q.conv_setup_q[`BIT_RUNSEL]; // RULE5
	assign chop_select               = r_q.conv_setup_q[`CHOP_HI:`CHOP_LO]; // RULE6
	assign filter_select             = r_q.filter_bias_q[`FILT_HI:`FILT_LO]; // RULE8
	assign bias_converter_route      = r_q.filter_bias_q[`BIT_BROUTE]; // RULE9
	assign bias_polarity             = r_q.filter_bias_q[`BIT_BPOL]; // RULE10
	assign bias_magnitude            = r_q.filter_bias_q[`BMAG_HI:`BMAG_LO]; // RULE11
	assign conv_busy  = (r_q.st_q != mode_config_pkg::ST_IDLE);
	assign conv_begin = (r_q.st_q == mode_config_pkg::ST_CONV);
	// fir clamp is registered so the rate output comes from a flop
	assign data_rate  = r_q.data_rate_q; // RULE15

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_start_seen;
		start_rise && r_q.st_q == mode_config_pkg::ST_IDLE;
	endsequence

	sequence s_no_delay_begin;
		##2 conv_begin;
	endsequence

	sequence s_setup_write;
		wr && idx == `IDX_CONV_SETUP;
	endsequence

	sequence s_filter_write;
		wr && idx == `IDX_FILTER_BIAS;
	endsequence

	sequence s_one_shot_end;
		conv_begin && done_s2_q && conversion_run_select;
	endsequence

	link_reserved_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		r_q.serial_link_q[7:4] == 4'h0)
		else $error("reserved serial link bits not zero");

	link_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		wr && idx == `IDX_SERIAL_LINK |=> timeout_enable == $past(pwdata[`BIT_TIMEOUT]))
		else $error("time-out enable did not follow write");

	status_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		wr && idx == `IDX_SERIAL_LINK |=> status_byte_enable == $past(pwdata[`BIT_STATUS]))
		else $error("status byte enable did not follow write");

	trailer_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		wr && idx == `IDX_SERIAL_LINK |=> integrity_select == $past(pwdata[1:0]))
		else $error("integrity select did not follow write");

	setup_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		acc && !pwrite && idx == `IDX_CONV_SETUP
		|-> prdata == {24'h000000, r_q.conv_setup_q})
		else $error("conversion setup read mismatch");

	filter_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		acc && !pwrite && idx == `IDX_FILTER_BIAS
		|-> prdata[7:0] == {filter_select, bias_converter_route, bias_polarity, bias_magnitude})
		else $error("filter and bias read mismatch");

	setup_fields_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		wr && idx == `IDX_CONV_SETUP |=> {reference_polarity_invert, conversion_run_select,
		chop_select} == $past(pwdata[7:4]))
		else $error("conversion setup fields did not follow write");

	zero_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		s_start_seen and r_q.conv_setup_q[`DELAY_HI:`DELAY_LO] == 4'h0 |-> s_no_delay_begin)
		else $error("zero delay start did not begin in two cycles");

	one_shot_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		s_one_shot_end |=> !conv_busy)
		else $error("one-shot did not stop after conversion");

	fir_rate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		filter_select == `CODE_FIR |-> data_rate inside {4'h0, 4'h1, `FIR_RATE_10, `FIR_RATE_20})
		else $error("rate outside FIR set");

	chop_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		s_setup_write |=> chop_select == $past(pwdata[`CHOP_HI:`CHOP_LO]))
		else $error("chop select did not follow write");

	delay_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		s_setup_write
		|=> r_q.conv_setup_q[`DELAY_HI:`DELAY_LO] == $past(pwdata[`DELAY_HI:`DELAY_LO]))
		else $error("start delay code did not follow write");

	filter_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		s_filter_write |=> filter_select == $past(filt_w))
		else $error("filter select did not follow write");

	route_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		s_filter_write |=> bias_converter_route == $past(pwdata[`BIT_BROUTE]))
		else $error("bias route did not follow write");

	polarity_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		s_filter_write |=> bias_polarity == $past(pwdata[`BIT_BPOL]))
		else $error("bias polarity did not follow write");

	magnitude_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		s_filter_write |=> bias_magnitude == $past(pwdata[`BMAG_HI:`BMAG_LO]))
		else $error("bias magnitude did not follow write");

	link_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		acc && !pwrite && idx == `IDX_SERIAL_LINK |-> prdata[31:4] == 28'h0000000)
		else $error("serial link read shows reserved bits");

	unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		acc && !pwrite && !mapped |-> prdata == 32'h00000000)
		else $error("unmapped read not zero");

	unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		wr && !mapped |=> r_q.conv_setup_q == $past(r_q.conv_setup_q))
		else $error("unmapped write changed conversion setup");

	strobe_guard_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		acc && pwrite && !pstrb[0]
		|=> {r_q.serial_link_q, r_q.conv_setup_q, r_q.filter_bias_q}
		== $past({r_q.serial_link_q, r_q.conv_setup_q, r_q.filter_bias_q}))
		else $error("write without byte strobe changed a register");

	read_stands_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		!rd_setup |=> $stable(prdata))
		else $error("read data changed outside a read setup");

	rate_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		wr && idx == `IDX_RATE_REQ |=> r_q.rate_req_q == $past(pwdata[3:0]))
		else $error("rate request did not follow write");

	fir_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		filter_select == `CODE_FIR && r_q.rate_req_q == `FIR_GAP_RATE
		|-> data_rate == `FIR_RATE_20)
		else $error("gap rate not lifted to 20 SPS under FIR");

	rate_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		filter_select != `CODE_FIR |-> data_rate == r_q.rate_req_q)
		else $error("rate request altered outside FIR");

	delay_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		r_q.st_q == mode_config_pkg::ST_WAIT && r_q.delay_cnt_q != 19'h00000
		|=> !conv_begin)
		else $error("conversion began before the delay ran out");

	state_onehot_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		$onehot(r_q.st_q))
		else $error("sequencer state not one-hot");

	run_continuous_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		conv_begin && !conversion_run_select |=> conv_begin)
		else $error("continuous conversion stopped");

	idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		!conv_busy && !start_rise |=> !conv_busy)
		else $error("sequencer left idle without a start");
endmodule

/* dv/apb_host.sv */
// host model: an apb master that runs one transfer at a time
// assumes a free-running pclk; the caller enters a task just after an edge
`timescale 1ns/1ns

module apb_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb
);
	bit   hung;
	logic err;

	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		hung = 0;
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		pstrb  <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		hung = (n >= 16);
		err = pslverr;
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		// one idle cycle so the next setup never lands on the release edge
		@(posedge pclk);
	endtask
endmodule

/* dv/adc_mode_config_regs_test.sv */
// self-checking bench for the mode configuration register block
// assumes apb_host drives the bus; the bench drives the conversion pins
`timescale 1ns/1ns

module adc_mode_config_regs_test;
	logic        pclk, presetn, conv_start, conv_done, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, data_rate;
	logic        conv_begin, conv_busy, timeout_enable, status_byte_enable;
	logic        reference_polarity_invert, conversion_run_select;
	logic        bias_converter_route, bias_polarity;
	logic [1:0]  integrity_select, chop_select;
	logic [2:0]  filter_select, bias_magnitude;
	int          failures, cmp_count, n;
	typedef struct { logic [11:0] a; logic [7:0] d; logic [7:0] q; } row_s;
	// reserved codes stay out of every row; only the first writes ones to reserved bits
	row_s        rows[] = '{'{12'h008, 8'hF6, 8'h06}, '{12'h008, 8'h0A, 8'h0A},
		'{12'h008, 8'h0D, 8'h0D}, '{12'h008, 8'h00, 8'h00}, '{12'h00C, 8'h80, 8'h80},
		'{12'h00C, 8'h5B, 8'h5B}, '{12'h00C, 8'h2A, 8'h2A}, '{12'h00C, 8'h31, 8'h31},
		'{12'h010, 8'h00, 8'h00}, '{12'h010, 8'h35, 8'h35}, '{12'h010, 8'h4B, 8'h4B},
		'{12'h010, 8'h7E, 8'h7E}, '{12'h010, 8'h11, 8'h11}, '{12'h010, 8'h42, 8'h42},
		'{12'h010, 8'h9C, 8'h9C}};
	logic [11:0] rst_a[3] = '{12'h008, 12'h00C, 12'h010};
	logic [7:0]  rst_q[3] = '{8'h05, 8'h00, 8'h80};
	logic [15:0] fir[4] = '{16'h8034, 16'h8094, 16'h8022, 16'h0033};

	mode_config_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .conv_start, .conv_begin, .conv_busy, .conv_done,
		.timeout_enable, .status_byte_enable, .integrity_select, .reference_polarity_invert,
		.conversion_run_select, .chop_select, .filter_select, .bias_converter_route,
		.bias_polarity, .bias_magnitude, .data_rate);
	apb_host host_u (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb);

	function automatic logic [7:0] view(input logic [11:0] a);
		case (a)
			12'h008: return {4'h0, timeout_enable, status_byte_enable, integrity_select};
			12'h00C: return {reference_polarity_invert, conversion_run_select, chop_select, 4'h0};
			default: return {filter_select, bias_converter_route, bias_polarity, bias_magnitude};
		endcase
	endfunction

	// the start delay has no port, so its nibble is masked out of the view
	function automatic logic [7:0] msk(input logic [11:0] a);
		return (a == 12'h00C) ? 8'hF0 : 8'hFF;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		host_u.xfer(w, a, d, s, rd);
		if (host_u.hung) begin
			failures++;
			test_done();
		end
	endtask

	task automatic wait_on(ref logic s, input logic v, input int lim);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (s !== v && n < lim);
		if (n >= lim) begin
			failures++;
			test_done();
		end
	endtask

	task automatic reset_run();
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({conv_busy, data_rate}, 5'h04);
		foreach (rst_a[i]) begin
			acc(0, rst_a[i], 0, 4'hF);
			chk(rd, rst_q[i]);
			chk(view(rst_a[i]), rst_q[i] & msk(rst_a[i]));
		end
		$display("reset values done");
	endtask

	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end

	initial begin
		{presetn, conv_start, conv_done} = '0;
		reset_run();
		foreach (rows[i]) begin
			acc(1, rows[i].a, {24'h0, rows[i].d}, 4'h1);
			acc(0, rows[i].a, 0, 4'hF);
			chk(rd, rows[i].q);
			chk(view(rows[i].a), rows[i].q & msk(rows[i].a));
		end
		$display("register rows done");
		acc(1, 12'h00C, 32'hFF, 4'hE);
		acc(0, 12'h00C, 0, 4'hF);
		chk(rd, 32'h31);
		acc(1, 12'h040, 32'hFF, 4'hF);
		chk(host_u.err, 1);
		acc(0, 12'h040, 0, 4'hF);
		chk(rd, 0);
		$display("strobe and unmapped done");
		foreach (fir[i]) begin
			acc(1, 12'h010, {24'h0, fir[i][15:8]}, 4'h1);
			acc(1, 12'h014, {28'h0, fir[i][7:4]}, 4'h1);
			chk(data_rate, fir[i][3:0]);
		end
		$display("rate clamp done");
		// one-shot with the shortest nonzero delay, 8.7 us at 20 ns a cycle
		acc(1, 12'h00C, 32'h41, 4'h1);
		conv_start <= 1'b1;
		wait_on(conv_begin, 1'b1, 600);
		chk(n >= 436 && n <= 442, 1);
		chk(conv_busy, 1);
		conv_done  <= 1'b1;
		conv_start <= 1'b0;
		wait_on(conv_busy, 1'b0, 8);
		chk(conv_begin, 0);
		conv_done <= 1'b0;
		acc(1, 12'h00C, 32'h00, 4'h1);
		conv_start <= 1'b1;
		wait_on(conv_begin, 1'b1, 12);
		chk(n <= 6, 1);
		repeat (20) @(posedge pclk);
		chk(conv_begin, 1);
		conv_start <= 1'b0;
		$display("conversion sequencing done");
		reset_run();
		test_done();
	end
endmodule
